// ---- verilog/gcr_pkg.sv ----
// gauge control register: shared constants, types and helpers
// assumes a 10 MHz core clock and an external serial byte interface
package gcr_pkg;
    // ======================================================
    // control register layout
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int PRE_HI = 5;
    localparam int PRE_LO = 3;
    localparam int PIN_HI = 2;
    localparam int PIN_LO = 1;
    localparam int SHDN_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h3C;
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_MANUAL = 2'h1;
    localparam logic [1:0] MODE_SCAN = 2'h2;
    localparam logic [1:0] MODE_AUTO = 2'h3;
    localparam logic [1:0] PIN_OFF = 2'h0;
    localparam logic [1:0] PIN_CHG_DONE = 2'h1;
    localparam logic [1:0] PIN_ALERT = 2'h2;

    // ======================================================
    // charge tally and prescaler
    localparam int TALLY_W = 16;
    localparam logic [15:0] TALLY_RESET = 16'h7FFF;
    localparam logic [15:0] TALLY_FULL = 16'hFFFF;
    localparam logic [15:0] TALLY_EMPTY = 16'h0000;
    localparam int PRE_W = 12;
    localparam logic [2:0] PRE_CODE_MAX = 3'h6;

    // ======================================================
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int SCAN_SLEEP_S = 10;
    localparam int SCAN_SLEEP_CYC = CLK_HZ * SCAN_SLEEP_S;
    localparam int NAP_W = 27;

    // ======================================================
    // types
    typedef enum logic [1:0] {GCR_IDLE, GCR_CONV, GCR_NAP} gcr_seq_e;

    typedef struct packed {
        logic thresh;
        logic seq_done;
        logic ara_done;
    } gcr_evt_s;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] tally;
        logic alert;
        gcr_seq_e seq;
        logic conv_run;
        logic analog_en;
        logic nap_go;
        logic pin_level;
    } gcr_top_s;

    // prescale wrap point: factor minus one, codes above 6 clamp
    function automatic logic [11:0] gcr_pre_limit(input logic [2:0] code);
        logic [2:0] c;
        c = (code > PRE_CODE_MAX) ? PRE_CODE_MAX : code;
        return 12'((24'h1 << (2 * c)) - 24'h1);
    endfunction : gcr_pre_limit
endpackage : gcr_pkg

// ---- verilog/gcr_prescaler.sv ----
// coulomb prescaler: divides integrator pulses by the selected factor
// assumes one-cycle up/down pulses from the analog integrator
`timescale 1ns/1ps
module gcr_prescaler #(
    parameter int W = gcr_pkg::PRE_W
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic [2:0] i_code,
    input wire logic i_clear,
    input wire logic i_up,
    input wire logic i_dn,
    output logic o_step_up,
    output logic o_step_dn
);
    typedef struct packed {
        logic [W-1:0] pos;
        logic up;
        logic dn;
    } gcr_pre_s;

    gcr_pre_s st;
    gcr_pre_s next_st;
    logic [W-1:0] lim;

    initial begin
        if (W != gcr_pkg::PRE_W) $error("prescaler width must be 12");
    end

    // ======================================================
    // divide, wrap and step
    always_comb begin
        lim = gcr_pkg::gcr_pre_limit(i_code);
        next_st = st;
        next_st.up = 1'b0;
        next_st.dn = 1'b0;
        if (i_clear) begin
            next_st.pos = '0; // partial charge dropped
        end else if (i_up && !i_dn) begin
            if (st.pos >= lim) begin
                next_st.pos = '0;
                next_st.up = 1'b1;
            end else begin
                next_st.pos = st.pos + W'(1);
            end
        end else if (i_dn && !i_up) begin
            if (st.pos == '0) begin
                next_st.pos = lim;
                next_st.dn = 1'b1;
            end else begin
                next_st.pos = st.pos - W'(1);
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '0;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_step_up = st.up;
    assign o_step_dn = st.dn;

    a_wrap_steps_up: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_ce && !i_clear && i_up && !i_dn && st.pos >= lim |=> o_step_up)
        else $error("prescaler wrap gave no up step");
    a_clear_no_step: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_ce && i_clear |=> !o_step_up && !o_step_dn && st.pos == '0)
        else $error("step seen while prescaler cleared");
endmodule : gcr_prescaler

// ---- verilog/gcr_nap_timer.sv ----
// scan pause timer: one pulse a fixed count after a start pulse
// assumes start pulses come only from the sequencer
`timescale 1ns/1ps
module gcr_nap_timer #(
    parameter int CYC = gcr_pkg::SCAN_SLEEP_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic i_start,
    output logic o_expired
);
    typedef struct packed {
        logic [gcr_pkg::NAP_W-1:0] cnt;
        logic busy;
        logic done;
    } gcr_nap_s;

    gcr_nap_s st;
    gcr_nap_s next_st;

    initial begin
        if (CYC < 1 || CYC >= (1 << gcr_pkg::NAP_W))
            $error("pause count out of range");
    end

    // ======================================================
    // count down the pause
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (i_start) begin
            next_st.cnt = gcr_pkg::NAP_W'(CYC - 1);
            next_st.busy = 1'b1;
        end else if (st.busy) begin
            if (st.cnt == '0) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.cnt = st.cnt - gcr_pkg::NAP_W'(1);
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '0;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_expired = st.done;

    a_pause_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_ce && i_start |=> st.busy && !o_expired)
        else $error("pause did not start");
endmodule : gcr_nap_timer

// ---- verilog/gcr_top.sv ----
// gauge control register with converter sequencer, charge tally and pin
// assumes the serial side gives one write strobe per acknowledged byte
`timescale 1ns/1ps
module gcr_top #(
    parameter int SCAN_CYC = gcr_pkg::SCAN_SLEEP_CYC,
    parameter int TALLY_W = gcr_pkg::TALLY_W
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic i_wr_en,
    input wire logic [7:0] i_wr_data,
    input wire gcr_pkg::gcr_evt_s i_evt,
    input wire logic i_int_up,
    input wire logic i_int_dn,
    input wire logic i_alert_charge_done_pin_in,
    output logic [7:0] o_ctrl,
    output logic [15:0] o_charge_tally,
    output logic o_conv_run,
    output logic o_analog_en,
    output logic o_alert_charge_done_pin_out,
    output logic o_alert_charge_done_pin_oe
);
    gcr_pkg::gcr_top_s st;
    gcr_pkg::gcr_top_s next_st;
    logic step_up;
    logic step_dn;
    logic nap_done;
    logic [1:0] mode;
    logic [1:0] pin_cfg;
    logic shdn;
    logic wrap;
    logic alert_evt;
    logic manual_end;

    initial begin
        if (TALLY_W != 16) $error("charge tally must be 16 bits");
    end

    // ======================================================
    // field decode of the live register
    assign mode = st.ctrl[gcr_pkg::MODE_HI:gcr_pkg::MODE_LO];
    assign pin_cfg = st.ctrl[gcr_pkg::PIN_HI:gcr_pkg::PIN_LO];
    assign shdn = st.ctrl[gcr_pkg::SHDN_BIT];

    // ======================================================
    // prescaler, cleared while the analog side is down
    gcr_prescaler #(
        .W(gcr_pkg::PRE_W)
    ) u_pre (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_code(st.ctrl[gcr_pkg::PRE_HI:gcr_pkg::PRE_LO]),
        .i_clear(shdn),
        .i_up(i_int_up),
        .i_dn(i_int_dn),
        .o_step_up(step_up),
        .o_step_dn(step_dn)
    );

    // ======================================================
    // pause between scan sequences
    gcr_nap_timer #(
        .CYC(SCAN_CYC)
    ) u_nap (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_start(st.nap_go),
        .o_expired(nap_done)
    );

    // ======================================================
    // event terms
    assign wrap = (step_up && st.tally == gcr_pkg::TALLY_FULL) ||
                  (step_dn && st.tally == gcr_pkg::TALLY_EMPTY);
    assign alert_evt = i_evt.thresh || wrap;
    assign manual_end = st.seq == gcr_pkg::GCR_CONV && i_evt.seq_done &&
                        mode == gcr_pkg::MODE_MANUAL;

    // ======================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.nap_go = 1'b0;
        next_st.pin_level = 1'b0;

        // register write wins over the manual auto clear
        // writes are taken whatever the shutdown bit says
        if (i_wr_en) begin
            next_st.ctrl = i_wr_data;
        end else if (manual_end) begin
            next_st.ctrl[gcr_pkg::MODE_HI:gcr_pkg::MODE_LO] =
                gcr_pkg::MODE_SLEEP;
        end
        next_st.analog_en = !next_st.ctrl[gcr_pkg::SHDN_BIT];

        // converter sequencer
        unique case (st.seq)
            gcr_pkg::GCR_IDLE: begin
                if (!shdn && mode != gcr_pkg::MODE_SLEEP) begin
                    next_st.seq = gcr_pkg::GCR_CONV;
                    next_st.conv_run = 1'b1;
                end
            end
            gcr_pkg::GCR_CONV: begin
                // mode is only looked at once the sequence is over
                if (i_evt.seq_done) begin
                    next_st.conv_run = 1'b0;
                    if (mode == gcr_pkg::MODE_SCAN) begin
                        next_st.seq = gcr_pkg::GCR_NAP;
                        next_st.nap_go = 1'b1;
                    end else if (mode == gcr_pkg::MODE_AUTO && !shdn) begin
                        next_st.conv_run = 1'b1;
                    end else begin
                        next_st.seq = gcr_pkg::GCR_IDLE;
                    end
                end
            end
            gcr_pkg::GCR_NAP: begin
                if (mode != gcr_pkg::MODE_SCAN) begin
                    next_st.seq = gcr_pkg::GCR_IDLE;
                end else if (nap_done) begin
                    if (shdn) begin
                        next_st.seq = gcr_pkg::GCR_IDLE;
                    end else begin
                        next_st.seq = gcr_pkg::GCR_CONV;
                        next_st.conv_run = 1'b1;
                    end
                end
            end
            default: begin
                next_st.seq = gcr_pkg::GCR_IDLE;
                next_st.conv_run = 1'b0;
            end
        endcase

        // charge tally: pin load first, then prescaler steps
        if (pin_cfg == gcr_pkg::PIN_CHG_DONE && !i_alert_charge_done_pin_in) begin
            next_st.tally = gcr_pkg::TALLY_FULL;
        end else if (step_up) begin
            next_st.tally = st.tally + 16'h0001;
        end else if (step_dn) begin
            next_st.tally = st.tally - 16'h0001;
        end

        // alert latch: set beats the response clear
        if (pin_cfg == gcr_pkg::PIN_ALERT && alert_evt) begin
            next_st.alert = 1'b1;
        end else if (i_evt.ara_done) begin
            next_st.alert = 1'b0;
        end
    end

    // ======================================================
    // state register, frozen by clock enable
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st.ctrl <= gcr_pkg::CTRL_RESET;
            st.tally <= gcr_pkg::TALLY_RESET;
            st.alert <= 1'b0;
            st.seq <= gcr_pkg::GCR_IDLE;
            st.conv_run <= 1'b0;
            st.analog_en <= 1'b1;
            st.nap_go <= 1'b0;
            st.pin_level <= 1'b0;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    // ======================================================
    // outputs, all straight from the state register
    assign o_ctrl = st.ctrl;
    assign o_charge_tally = st.tally;
    assign o_conv_run = st.conv_run;
    assign o_analog_en = st.analog_en;
    assign o_alert_charge_done_pin_out = st.pin_level;
    // pin pulled only by a held alert, whatever the field says
    assign o_alert_charge_done_pin_oe = st.alert;

    // ======================================================
    // checks
    a_manual_clears: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        i_ce && manual_end && !i_wr_en |=>
            o_ctrl[7:6] == 2'h0 && !o_conv_run)
        else $error("manual sequence left mode set");
    a_write_takes: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        i_ce && i_wr_en |=> o_ctrl == $past(i_wr_data))
        else $error("written byte not in register");
    a_alert_sets: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        i_ce && pin_cfg == 2'h2 && (i_evt.thresh || wrap)
            |=> o_alert_charge_done_pin_oe && !o_alert_charge_done_pin_out)
        else $error("alert event did not pull pin");
    a_alert_holds: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        o_alert_charge_done_pin_oe && !i_evt.ara_done |=> o_alert_charge_done_pin_oe)
        else $error("alert dropped without response");
    a_ara_release: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        i_ce && o_alert_charge_done_pin_oe && i_evt.ara_done && !i_evt.thresh && !wrap
            |=> !o_alert_charge_done_pin_oe)
        else $error("alert response did not release pin");
    a_pin_unused: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        pin_cfg == 2'h0 && !o_alert_charge_done_pin_oe && !i_evt.thresh ##1
            pin_cfg == 2'h0 && !step_up && !step_dn && !i_wr_en
            |=> !o_alert_charge_done_pin_oe && $stable(o_charge_tally))
        else $error("disabled pin drove or was sampled");
    a_charge_full: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        i_ce && pin_cfg == 2'h1 && !i_alert_charge_done_pin_in |=> o_charge_tally == 16'hFFFF)
        else $error("charge done did not fill tally");
    a_shutdown_still: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        shdn && pin_cfg != 2'h1 ##1 shdn && pin_cfg != 2'h1
            |=> $stable(o_charge_tally))
        else $error("tally moved in shutdown");
    a_shutdown_regs: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        i_ce && shdn && !i_wr_en && !manual_end |=> $stable(o_ctrl) &&
            !o_analog_en)
        else $error("register changed in shutdown");
    a_tally_wraps: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        i_ce && step_up && st.tally == 16'hFFFF && pin_cfg != 2'h1
            |=> o_charge_tally == 16'h0000)
        else $error("tally did not roll over");
    a_seq_finishes: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        o_conv_run && !i_evt.seq_done |=> o_conv_run)
        else $error("sequence cut short");
    a_scan_pauses: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        i_ce && st.seq == gcr_pkg::GCR_CONV && i_evt.seq_done &&
            mode == 2'h2 |=> st.nap_go && !o_conv_run)
        else $error("scan did not pause");
endmodule : gcr_top

// ---- verification/gcr_charger_model.sv ----
// board side of the dual-purpose pin: pull-up resistor plus a charger
// assumes the block only sinks the pin while its output enable is high
`timescale 1ns/1ps
module gcr_charger_model (
    input wire logic i_oe,
    input wire logic i_out,
    input wire logic i_pull,
    output logic o_pin
);
    // ==========================================================
    // wired level
    // pull-up wins unless the block or the charger sinks the line
    assign o_pin = ((i_oe && !i_out) || i_pull) ? 1'b0 : 1'b1;
endmodule : gcr_charger_model

// ---- verification/gcr_top_tb_top.sv ----
// self-checking bench for the gauge control register block
// assumes the design package, design sources and charger model compile first
`timescale 1ns/1ps
module gcr_top_tb_top;
    // ==========================================================
    // stimulus and observation
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic wr_en = 1'b0;
    logic [7:0] wr_data = 8'h00;
    gcr_pkg::gcr_evt_s evt = '0;
    logic up = 1'b0;
    logic dn = 1'b0;
    logic pull = 1'b0;
    logic pin;
    logic [7:0] ctrl;
    logic [15:0] tally;
    logic run;
    logic aen;
    logic aout;
    logic aoe;
    logic [15:0] exp_t = 16'h7FFF;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;

    // ==========================================================
    // design, short scan pause, and the board model
    gcr_top #(.SCAN_CYC(20), .TALLY_W(16)) gcr_top_inst (
        .i_clk(clk), .i_sys_rst(rst), .i_ce(ce),
        .i_wr_en(wr_en), .i_wr_data(wr_data), .i_evt(evt),
        .i_int_up(up), .i_int_dn(dn), .i_alert_charge_done_pin_in(pin),
        .o_ctrl(ctrl), .o_charge_tally(tally), .o_conv_run(run),
        .o_analog_en(aen), .o_alert_charge_done_pin_out(aout), .o_alert_charge_done_pin_oe(aoe)
    );
    gcr_charger_model gcr_charger_model_inst (
        .i_oe(aoe), .i_out(aout), .i_pull(pull), .o_pin(pin)
    );

    // clock and hang guard
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            fails++;
            close_out();
        end
    end

    // ==========================================================
    // shared helpers
    task automatic close_out();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] got, input logic [15:0] want,
                       input string what);
        total_checks++;
        if (got !== want) begin
            fails++;
            $display("unexpected at %0t: %s %h not %h", $time, what, got,
                     want);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // one acknowledged byte; never 11 in the pin field
    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr

    // n integrator pulses back to back, then let the tally settle
    task automatic pulse(input logic u, input int n);
        repeat (n) begin
            @(posedge clk);
            up <= u;
            dn <= !u;
        end
        @(posedge clk);
        up <= 1'b0;
        dn <= 1'b0;
        tick(4);
    endtask : pulse

    task automatic ev(input gcr_pkg::gcr_evt_s e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= '0;
        tick(1);
    endtask : ev

    task automatic wait_run(input logic v, input int lim, output int n);
        n = 0;
        while (run !== v && n < lim) begin
            tick(1);
            n++;
        end
    endtask : wait_run

    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk(16'(ctrl), 16'h003C, "reset ctrl");
        chk(tally, 16'h7FFF, "reset tally");
        chk(16'(aen), 16'h0001, "reset analog");
        chk(16'(aoe), 16'h0000, "reset pin drive");
    endtask : t_reset

    // every prescale code: no step one pulse short, a step at the factor
    task automatic t_prescale();
        int m;
        for (int c = 0; c < 8; c++) begin
            m = (c > 5) ? 4096 : (1 << (2 * c));
            wr({2'b00, 3'(c), 3'b000});
            pulse(1'b1, m - 1);
            chk(tally, exp_t, "tally before wrap");
            pulse(1'b1, 1);
            exp_t = exp_t + 16'h0001;
            chk(tally, exp_t, "tally step up");
        end
        wr(8'h08);
        pulse(1'b0, 4);
        exp_t = exp_t - 16'h0001;
        chk(tally, exp_t, "tally step down");
    endtask : t_prescale

    // shutdown mid-step: pulses lost, remainder dropped, writes still work
    task automatic t_shutdown();
        pulse(1'b1, 3);
        wr(8'h09);
        chk(16'(aen), 16'h0000, "analog off");
        pulse(1'b1, 5);
        chk(tally, exp_t, "no count in shutdown");
        wr(8'h11);
        chk(16'(ctrl), 16'h0011, "write in shutdown");
        wr(8'h08);
        chk(16'(aen), 16'h0001, "analog on");
        pulse(1'b1, 3);
        chk(tally, exp_t, "remainder dropped");
        pulse(1'b1, 1);
        exp_t = exp_t + 16'h0001;
        chk(tally, exp_t, "fresh step");
    endtask : t_shutdown

    task automatic t_pin();
        wr(8'h02);
        @(posedge clk);
        pull <= 1'b1;
        @(posedge clk);
        pull <= 1'b0;
        tick(2);
        exp_t = 16'hFFFF;
        chk(tally, exp_t, "charge done load");
        wr(8'h00);
        pulse(1'b0, 1);
        exp_t = exp_t - 16'h0001;
        @(posedge clk);
        pull <= 1'b1;
        @(posedge clk);
        pull <= 1'b0;
        ev(3'b100);
        chk(tally, exp_t, "pin ignored when off");
        chk(16'(aoe), 16'h0000, "no alert when off");
        wr(8'h04);
        pulse(1'b1, 2);
        exp_t = 16'h0000;
        tick(1);
        chk(tally, exp_t, "tally wraps up");
        chk(16'(aoe), 16'h0001, "alert on wrap");
        chk(16'(pin), 16'h0000, "pin pulled low");
        wr(8'h00);
        tick(3);
        chk(16'(aoe), 16'h0001, "alert held over rewrite");
        ev(3'b001);
        tick(1);
        chk(16'(aoe), 16'h0000, "alert response frees");
        wr(8'h04);
        ev(3'b100);
        chk(16'(aoe), 16'h0001, "alert on threshold");
        tick(5);
        chk(16'(aoe), 16'h0001, "alert stays");
        ev(3'b001);
        tick(1);
        chk(16'(aoe), 16'h0000, "second response frees");
        pulse(1'b0, 1);
        exp_t = 16'hFFFF;
        tick(1);
        chk(tally, exp_t, "tally wraps down");
        chk(16'(aoe), 16'h0001, "alert on underflow");
        ev(3'b001);
        tick(1);
        // clock enable low: pulses must leave no trace
        @(posedge clk);
        ce <= 1'b0;
        pulse(1'b1, 2);
        chk(tally, exp_t, "tally frozen by enable");
        @(posedge clk);
        ce <= 1'b1;
        tick(1);
        pulse(1'b1, 1);
        exp_t = exp_t + 16'h0001;
        chk(tally, exp_t, "tally counts after enable");
    endtask : t_pin

    task automatic t_seq();
        int n;
        wr(8'h40);
        wait_run(1'b1, 4, n);
        chk(16'(run), 16'h0001, "manual starts");
        ev(3'b010);
        tick(1);
        chk(16'(run), 16'h0000, "manual ends");
        chk(16'(ctrl), 16'h0000, "mode cleared");
        wr(8'hC0);
        wait_run(1'b1, 4, n);
        ev(3'b010);
        tick(2);
        chk(16'(run), 16'h0001, "auto repeats");
        wr(8'h00);
        tick(2);
        chk(16'(run), 16'h0001, "run finishes first");
        ev(3'b010);
        tick(5);
        chk(16'(run), 16'h0000, "sleep after run");
        wr(8'h80);
        wait_run(1'b1, 4, n);
        ev(3'b010);
        wait_run(1'b0, 3, n);
        wait_run(1'b1, 40, n);
        chk(16'(n >= 18 && n <= 24), 16'h0001, "scan pause");
        wr(8'h00);
        ev(3'b010);
        tick(30);
        chk(16'(run), 16'h0000, "scan left");
    endtask : t_seq

    // ==========================================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_prescale();
        t_shutdown();
        t_pin();
        t_seq();
        close_out();
    end
endmodule : gcr_top_tb_top
